/* inc/pms_pkg.sv */
// Power mode sequencer package: mode encodings and timing constants.
// Assumes a single 40 MHz clock domain.
package pms_pkg;

    // ==================================================================
    // Power modes
    typedef enum logic [3:0] {
        PMS_RUN,
        PMS_WAIT,
        PMS_STOP,
        PMS_PARTIAL_STOP_LEVEL_TWO,
        PMS_PARTIAL_STOP_LEVEL_ONE,
        PMS_VLP_RUN,
        PMS_VLP_WAIT,
        PMS_VLP_STOP
    } pms_mode_e;

    // Partial stop level select carried with a stop request
    typedef enum logic [1:0] {
        PMS_STOP_FULL,
        PMS_STOP_PART2,
        PMS_STOP_PART1
    } pms_stop_e;

    // ==================================================================
    // Timing
    localparam int unsigned CLK_HZ            = 40_000_000;
    localparam int unsigned FLASH_LP_HZ       = 1_000_000;
    localparam int unsigned OSC_LP_HZ         = 4_000_000;
    // Divider ratios derived from the clock rate
    localparam int unsigned FLASH_LP_DIV      = CLK_HZ / FLASH_LP_HZ;
    localparam int unsigned CORE_LP_DIV       = CLK_HZ / OSC_LP_HZ;
    localparam int unsigned DIV_W             = 8;

    // Reset values
    localparam logic        RST_LVD_ON        = 1'b1;
    localparam logic        RST_REG_LP        = 1'b0;
    localparam logic        RST_CLK_ON        = 1'b1;

endpackage : pms_pkg

/* src/pms_rate_div.sv */
// One-cycle enable pulse generator for the reduced-rate clocks.
// Assumes the single system clock; ratio must be at least one.
`timescale 1ns/100ps
module pms_rate_div #(
    parameter int unsigned W = 8
) (
    input  wire logic         clock,
    input  wire logic         nrst,
    input  wire logic         run,
    input  wire logic [W-1:0] ratio,
    output logic              tick
);

    logic [W-1:0] cnt_q;

    // ==================================================================
    // Counter, restarted whenever the rate is not in use
    always_ff @(posedge clock) begin
        if (!nrst || !run) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else if (cnt_q >= ratio - 1'b1) begin
            cnt_q <= '0;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            tick  <= 1'b0;
        end
    end

endmodule // pms_rate_div

/* src/pms_sequencer.sv */
// Power mode sequencer: run/wait/stop control with clock gating,
// regulator and low-voltage-detect control and I/O hold.
// Assumes core requests are synchronous one-cycle pulses on clock.
`timescale 1ns/100ps
module pms_sequencer
    import pms_pkg::*;
#(
    parameter int unsigned FLASH_DIV = FLASH_LP_DIV,
    parameter int unsigned CORE_DIV  = CORE_LP_DIV
) (
    input  wire logic              clock,
    input  wire logic              nrst,
    // Core side
    input  wire logic              sleep_instruction,
    input  wire logic              deep_sleep_select,
    input  wire pms_pkg::pms_stop_e stop_level,
    input  wire logic              vlp_run_req,
    input  wire logic              normal_run_req,
    input  wire logic              wake_irq,
    input  wire logic              dcdc_continuous,
    input  wire logic              radio_req,
    // Mode status
    output pms_pkg::pms_mode_e     mode_q,
    output logic                   core_clk_en_q,
    output logic                   sys_clk_en_q,
    output logic                   bus_clk_en_q,
    output logic                   bus_stop_q,
    output logic                   clkgen_run_q,
    output logic                   regulator_lp_q,
    output logic                   lvd_en_q,
    output logic                   flash_lp_q,
    output logic                   flash_tick_q,
    output logic                   core_lp_tick_q,
    output logic                   bias_en_q,
    output logic                   radio_allow_q,
    output logic                   io_hold_q,
    output logic                   lp_periph_en_q,
    output logic                   periph_clk_en_q
);

    // ==================================================================
    // Mode state
    pms_mode_e mode_d;
    logic      vlp_origin_q;
    logic      vlp_origin_d;
    logic      vlp_run_d;
    logic      flash_tick;
    logic      core_tick;
    logic      vlp_any;

    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            PMS_RUN: begin
                if (sleep_instruction) begin
                    if (!deep_sleep_select) begin
                        mode_d = PMS_WAIT;
                    end else if (stop_level == PMS_STOP_PART2) begin
                        mode_d = PMS_PARTIAL_STOP_LEVEL_TWO;
                    end else if (stop_level == PMS_STOP_PART1) begin
                        mode_d = PMS_PARTIAL_STOP_LEVEL_ONE;
                    end else begin
                        mode_d = PMS_STOP;
                    end
                end else if (vlp_run_req) begin
                    mode_d = PMS_VLP_RUN;
                end
            end
            PMS_VLP_RUN: begin
                if (sleep_instruction) begin
                    // Partial stops leave the regulator in low-power run
                    if (!deep_sleep_select) begin
                        mode_d = PMS_VLP_WAIT;
                    end else if (stop_level == PMS_STOP_PART2) begin
                        mode_d = PMS_PARTIAL_STOP_LEVEL_TWO;
                    end else if (stop_level == PMS_STOP_PART1) begin
                        mode_d = PMS_PARTIAL_STOP_LEVEL_ONE;
                    end else begin
                        mode_d = PMS_VLP_STOP;
                    end
                end else if (normal_run_req) begin
                    mode_d = PMS_RUN;
                end
            end
            PMS_WAIT,
            PMS_STOP: begin
                if (wake_irq) begin
                    mode_d = PMS_RUN;
                end
            end
            PMS_VLP_WAIT,
            PMS_VLP_STOP: begin
                if (wake_irq) begin
                    mode_d = PMS_VLP_RUN;
                end
            end
            PMS_PARTIAL_STOP_LEVEL_TWO,
            PMS_PARTIAL_STOP_LEVEL_ONE: begin
                if (wake_irq) begin
                    mode_d = vlp_origin_q ? PMS_VLP_RUN : PMS_RUN;
                end
            end
            default: mode_d = PMS_RUN;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            mode_q <= PMS_RUN;
        end else begin
            mode_q <= mode_d;
        end
    end

    // Origin run mode remembered for partial-stop wake. The regulator
    // decode uses the next value, so a sleep in the first cycle of a run
    // mode never sees the origin of the run mode before it.
    always_comb begin
        vlp_origin_d = vlp_origin_q;
        if (mode_q == PMS_RUN) begin
            vlp_origin_d = 1'b0;
        end else if (mode_q == PMS_VLP_RUN) begin
            vlp_origin_d = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            vlp_origin_q <= 1'b0;
        end else begin
            vlp_origin_q <= vlp_origin_d;
        end
    end

    // ==================================================================
    // Clock gating, decoded from the next mode so outputs track the state
    always_ff @(posedge clock) begin
        if (!nrst) begin
            core_clk_en_q   <= RST_CLK_ON;
            sys_clk_en_q    <= RST_CLK_ON;
            bus_clk_en_q    <= RST_CLK_ON;
            periph_clk_en_q <= RST_CLK_ON;
            bus_stop_q      <= 1'b0;
        end else begin
            core_clk_en_q   <= (mode_d == PMS_RUN)
                            || (mode_d == PMS_VLP_RUN);
            sys_clk_en_q    <= (mode_d == PMS_RUN)
                            || (mode_d == PMS_VLP_RUN)
                            || (mode_d == PMS_WAIT)
                            || (mode_d == PMS_VLP_WAIT);
            bus_clk_en_q    <= (mode_d != PMS_STOP)
                            && (mode_d != PMS_VLP_STOP)
                            && (mode_d != PMS_PARTIAL_STOP_LEVEL_ONE);
            periph_clk_en_q <= (mode_d == PMS_RUN)
                            || (mode_d == PMS_WAIT)
                            || (mode_d == PMS_VLP_RUN)
                            || (mode_d == PMS_VLP_WAIT)
                            || (mode_d == PMS_PARTIAL_STOP_LEVEL_TWO);
            bus_stop_q      <= (mode_d == PMS_STOP)
                            || (mode_d == PMS_VLP_STOP)
                            || (mode_d == PMS_PARTIAL_STOP_LEVEL_ONE);
        end
    end

    // ==================================================================
    // Regulator, clock generators and voltage detection
    assign vlp_any = (mode_d == PMS_VLP_RUN) || (mode_d == PMS_VLP_WAIT)
                  || (mode_d == PMS_VLP_STOP);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            regulator_lp_q <= RST_REG_LP;
            lvd_en_q       <= RST_LVD_ON;
            clkgen_run_q   <= 1'b1;
            flash_lp_q     <= 1'b0;
            lp_periph_en_q <= 1'b1;
        end else begin
            // Partial stops keep the regulator in its run-side setting
            regulator_lp_q <= vlp_any
                           || (((mode_d == PMS_PARTIAL_STOP_LEVEL_ONE)
                           || (mode_d == PMS_PARTIAL_STOP_LEVEL_TWO))
                           && vlp_origin_d);
            lvd_en_q       <= !vlp_any
                           && !(((mode_d == PMS_PARTIAL_STOP_LEVEL_ONE)
                           || (mode_d == PMS_PARTIAL_STOP_LEVEL_TWO))
                           && vlp_origin_d);
            clkgen_run_q   <= (mode_d != PMS_STOP)
                           && (mode_d != PMS_VLP_STOP);
            flash_lp_q     <= vlp_any;
            // Timer, clock, comparator, converter and pin wake stay alive
            lp_periph_en_q <= 1'b1;
        end
    end

    // ==================================================================
    // Radio and biasing in low-power modes
    always_ff @(posedge clock) begin
        if (!nrst) begin
            bias_en_q     <= 1'b1;
            radio_allow_q <= 1'b0;
        end else begin
            bias_en_q     <= !(((mode_d == PMS_VLP_RUN)
                          || (mode_d == PMS_VLP_WAIT))
                          && dcdc_continuous);
            if (mode_d == PMS_RUN) begin
                radio_allow_q <= radio_req;
            end else if (mode_d == PMS_VLP_RUN) begin
                radio_allow_q <= radio_req && dcdc_continuous;
            end else begin
                radio_allow_q <= 1'b0;
            end
        end
    end

    // ==================================================================
    // Pin state is held regardless of mode; mode changes never release it
    always_ff @(posedge clock) begin
        if (!nrst) begin
            io_hold_q <= 1'b1;
        end else begin
            io_hold_q <= 1'b1;
        end
    end

    // ==================================================================
    // Reduced-rate enables: 1 MHz flash and 4 MHz core in low-power run
    pms_rate_div #(
        .W     (DIV_W)
    ) u_flash_div (
        .clock (clock),
        .nrst  (nrst),
        .run   (mode_q == PMS_VLP_RUN),
        .ratio (DIV_W'(FLASH_DIV)),
        .tick  (flash_tick)
    );

    pms_rate_div #(
        .W     (DIV_W)
    ) u_core_div (
        .clock (clock),
        .nrst  (nrst),
        .run   (mode_q == PMS_VLP_RUN),
        .ratio (DIV_W'(CORE_DIV)),
        .tick  (core_tick)
    );

    assign vlp_run_d = (mode_d == PMS_VLP_RUN);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            flash_tick_q   <= 1'b0;
            core_lp_tick_q <= 1'b0;
        end else begin
            // Gated by the next mode so no stray tick follows an exit
            flash_tick_q   <= flash_tick && vlp_run_d;
            core_lp_tick_q <= core_tick && vlp_run_d;
        end
    end

endmodule // pms_sequencer

/* sim/pms_sequencer_props.sv */
// Concurrent checks on the power mode sequencer ports.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/100ps
module pms_sequencer_props
    import pms_pkg::*;
(
    input wire logic               clock,
    input wire logic               nrst,
    input wire logic               sleep_instruction,
    input wire logic               deep_sleep_select,
    input wire pms_pkg::pms_stop_e stop_level,
    input wire logic               wake_irq,
    input wire pms_pkg::pms_mode_e mode_q,
    input wire logic               core_clk_en_q,
    input wire logic               sys_clk_en_q,
    input wire logic               bus_clk_en_q,
    input wire logic               bus_stop_q,
    input wire logic               regulator_lp_q,
    input wire logic               lvd_en_q,
    input wire logic               flash_lp_q,
    input wire logic               io_hold_q
);
    import pms_pkg::*;
    // ==============================================================
    // Properties
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    property p_wait;
        sleep_instruction && !deep_sleep_select && mode_q == PMS_RUN
        |=> mode_q == PMS_WAIT;
    endproperty
    a_wait: assert property (p_wait) else $error("no wait");
    property p_stop;
        sleep_instruction && deep_sleep_select && mode_q == PMS_RUN &&
        stop_level == PMS_STOP_FULL |=> mode_q == PMS_STOP && lvd_en_q;
    endproperty
    a_stop: assert property (p_stop) else $error("no stop");
    property p_hold;
        $rose(nrst) |-> io_hold_q [*8];
    endproperty
    a_hold: assert property (p_hold) else $error("hold lost");
    property p_wclk;
        mode_q == PMS_WAIT |-> !core_clk_en_q && bus_clk_en_q;
    endproperty
    a_wclk: assert property (p_wclk) else $error("wait clocks");
    property p_pst2;
        mode_q == PMS_PARTIAL_STOP_LEVEL_TWO |-> !sys_clk_en_q && bus_clk_en_q;
    endproperty
    a_pst2: assert property (p_pst2) else $error("partial_stop_level_two");
    property p_pst1;
        mode_q == PMS_PARTIAL_STOP_LEVEL_ONE |-> !bus_clk_en_q && bus_stop_q;
    endproperty
    a_pst1: assert property (p_pst1) else $error("partial_stop_level_one");
    property p_very_low_power_run;
        mode_q == PMS_VLP_RUN |-> regulator_lp_q && !lvd_en_q && flash_lp_q;
    endproperty
    a_very_low_power_run: assert property (p_very_low_power_run) else $error("vlp run");
    property p_wake;
        wake_irq && mode_q == PMS_VLP_WAIT
        |=> mode_q == PMS_VLP_RUN && core_clk_en_q;
    endproperty
    a_wake: assert property (p_wake) else $error("wake");
    c_stop: cover property (mode_q == PMS_STOP);
    c_very_low_power_stop: cover property (mode_q == PMS_VLP_STOP);
    c_pst1: cover property (mode_q == PMS_PARTIAL_STOP_LEVEL_ONE);
endmodule // pms_sequencer_props

bind pms_sequencer pms_sequencer_props pms_sequencer_props_i (
    .clock             (clock),
    .nrst              (nrst),
    .sleep_instruction (sleep_instruction),
    .deep_sleep_select (deep_sleep_select),
    .stop_level        (stop_level),
    .wake_irq          (wake_irq),
    .mode_q            (mode_q),
    .core_clk_en_q     (core_clk_en_q),
    .sys_clk_en_q      (sys_clk_en_q),
    .bus_clk_en_q      (bus_clk_en_q),
    .bus_stop_q        (bus_stop_q),
    .regulator_lp_q    (regulator_lp_q),
    .lvd_en_q          (lvd_en_q),
    .flash_lp_q        (flash_lp_q),
    .io_hold_q         (io_hold_q)
);

/* sim/pms_core_model.sv */
// Core and interrupt source facing the sequencer.
// Assumes sleep_go is a one-cycle request made at a rising edge.
`timescale 1ns/100ps
module pms_core_model (
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       sleep_go,
    input  wire logic [3:0] wake_dly,
    input  wire logic       in_run,
    output logic            sleep_instruction,
    output logic            wake_irq
);
    logic [3:0] cnt_q;
    // The core executes a sleep only while it runs
    always_ff @(posedge clock) begin
        sleep_instruction <= nrst && sleep_go && in_run;
    end
    // Interrupt is a level held until the core runs again; 0 = never
    always_ff @(posedge clock) begin
        if (!nrst)
            cnt_q <= 4'h0;
        else if (sleep_instruction)
            cnt_q <= wake_dly;
        else if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
    end
    always_ff @(posedge clock) begin
        if (!nrst || in_run)
            wake_irq <= 1'b0;
        else if (cnt_q == 4'h1)
            wake_irq <= 1'b1;
    end
endmodule // pms_core_model

/* sim/test_pms_sequencer.sv */
// Self-checking bench for the power mode sequencer.
// Assumes the core model and the bound checker beside the design.
`timescale 1ns/100ps
module test_pms_sequencer;
    import pms_pkg::*;
    logic       clock = 1'b0;
    logic       nrst = 1'b0;
    logic       sleep_go = 1'b0;
    logic       deep_sleep_select = 1'b0;
    pms_stop_e  stop_level = PMS_STOP_FULL;
    logic       vlp_run_req = 1'b0;
    logic       normal_run_req = 1'b0;
    logic       dcdc_continuous = 1'b0;
    logic       radio_req = 1'b0;
    logic [3:0] wake_dly = 4'h3;
    logic       sleep_instruction, wake_irq, core_clk_en_q, sys_clk_en_q;
    logic       bus_clk_en_q, lvd_en_q, regulator_lp_q, flash_tick_q;
    logic       core_lp_tick_q, bias_en_q, radio_allow_q, io_hold_q;
    logic       bus_stop_q, clkgen_run_q, flash_lp_q, lp_periph_en_q;
    logic       periph_clk_en_q;
    pms_mode_e  mode_q;
    wire logic  in_run = mode_q == PMS_RUN || mode_q == PMS_VLP_RUN;
    wire logic [7:0] ctl = {core_clk_en_q, sys_clk_en_q, bus_clk_en_q,
        lvd_en_q, periph_clk_en_q, bus_stop_q, clkgen_run_q, regulator_lp_q};
    int         error_cnt = 0;
    int         compares = 0;
    int         n, m;
    // Row: from low-power run, deep, level, mode, controls
    // Controls: {core,sys,bus,lvd,periph,bus_stop,clkgen,reg_lp}
    localparam logic [15:0] ROWS [8] = '{
        {1'b0, 1'b0, PMS_STOP_FULL, PMS_WAIT, 8'h7A},
        {1'b0, 1'b1, PMS_STOP_FULL, PMS_STOP, 8'h14},
        {1'b0, 1'b1, PMS_STOP_PART2, PMS_PARTIAL_STOP_LEVEL_TWO, 8'h3A},
        {1'b0, 1'b1, PMS_STOP_PART1, PMS_PARTIAL_STOP_LEVEL_ONE, 8'h16},
        {1'b1, 1'b0, PMS_STOP_FULL, PMS_VLP_WAIT, 8'h6B},
        {1'b1, 1'b1, PMS_STOP_FULL, PMS_VLP_STOP, 8'h05},
        {1'b1, 1'b1, PMS_STOP_PART2, PMS_PARTIAL_STOP_LEVEL_TWO, 8'h2B},
        {1'b1, 1'b1, PMS_STOP_PART1, PMS_PARTIAL_STOP_LEVEL_ONE, 8'h07}};

    pms_sequencer #(
        .FLASH_DIV         (40),
        .CORE_DIV          (10)
    ) pms_sequencer_i (
        .clock             (clock),
        .nrst              (nrst),
        .sleep_instruction (sleep_instruction),
        .deep_sleep_select (deep_sleep_select),
        .stop_level        (stop_level),
        .vlp_run_req       (vlp_run_req),
        .normal_run_req    (normal_run_req),
        .wake_irq          (wake_irq),
        .dcdc_continuous   (dcdc_continuous),
        .radio_req         (radio_req),
        .mode_q            (mode_q),
        .core_clk_en_q     (core_clk_en_q),
        .sys_clk_en_q      (sys_clk_en_q),
        .bus_clk_en_q      (bus_clk_en_q),
        .bus_stop_q        (bus_stop_q),
        .clkgen_run_q      (clkgen_run_q),
        .regulator_lp_q    (regulator_lp_q),
        .lvd_en_q          (lvd_en_q),
        .flash_lp_q        (flash_lp_q),
        .flash_tick_q      (flash_tick_q),
        .core_lp_tick_q    (core_lp_tick_q),
        .bias_en_q         (bias_en_q),
        .radio_allow_q     (radio_allow_q),
        .io_hold_q         (io_hold_q),
        .lp_periph_en_q    (lp_periph_en_q),
        .periph_clk_en_q   (periph_clk_en_q)
    );
    pms_core_model pms_core_model_i (
        .clock             (clock),
        .nrst              (nrst),
        .sleep_go          (sleep_go),
        .wake_dly          (wake_dly),
        .in_run            (in_run),
        .sleep_instruction (sleep_instruction),
        .wake_irq          (wake_irq)
    );

    initial forever #12.5 clock = ~clock;

    // ==============================================================
    // Checking and closing
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %0h exp %0h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Bounded wait for the interrupt to bring the core back
    task automatic wait_run();
        n = 0;
        while (!in_run && n < 20) begin
            @(negedge clock);
            n++;
        end
        if (!in_run) begin
            error_cnt++;
            stop_test();
        end
    endtask
    task automatic sleep_now();
        @(posedge clock) sleep_go <= 1'b1;
        @(posedge clock) sleep_go <= 1'b0;
        @(posedge clock);
        @(negedge clock);
    endtask

    // ==============================================================
    // Sequence
    initial begin
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        @(negedge clock);
        chk(mode_q, PMS_RUN);
        chk({io_hold_q, lvd_en_q, bias_en_q}, 8'h07);
        @(posedge clock) radio_req <= 1'b1;
        repeat (3) @(negedge clock);
        chk(radio_allow_q, 8'h01);
        foreach (ROWS[i]) begin
            @(posedge clock) deep_sleep_select <= ROWS[i][14];
            stop_level <= pms_stop_e'(ROWS[i][13:12]);
            vlp_run_req <= ROWS[i][15];
            @(posedge clock) vlp_run_req <= 1'b0;
            sleep_go <= 1'b1;
            @(posedge clock) sleep_go <= 1'b0;
            @(posedge clock);
            @(negedge clock);
            chk(mode_q, ROWS[i][11:8]);
            chk(ctl, ROWS[i][7:0]);
            wait_run();
            chk(mode_q, ROWS[i][15] ? PMS_VLP_RUN : PMS_RUN);
            @(posedge clock) normal_run_req <= 1'b1;
            @(posedge clock) normal_run_req <= 1'b0;
            @(negedge clock);
            chk(mode_q, PMS_RUN);
        end
        @(posedge clock) vlp_run_req <= 1'b1;
        @(posedge clock) vlp_run_req <= 1'b0;
        repeat (50) @(negedge clock);
        chk({radio_allow_q, bias_en_q, regulator_lp_q}, 8'h03);
        chk(flash_lp_q, 8'h01);
        n = 0;
        m = 0;
        repeat (40) begin
            @(negedge clock);
            n += flash_tick_q;
            m += core_lp_tick_q;
        end
        chk(8'(n), 8'h01);
        chk(8'(m), 8'h04);
        @(posedge clock) dcdc_continuous <= 1'b1;
        deep_sleep_select <= 1'b0;
        wake_dly <= 4'hF;
        repeat (3) @(negedge clock);
        chk({radio_allow_q, bias_en_q}, 8'h02);
        sleep_now();
        chk({mode_q, bias_en_q}, {PMS_VLP_WAIT, 1'b0});
        // Run requests while asleep must change nothing
        @(posedge clock) normal_run_req <= 1'b1;
        vlp_run_req <= 1'b1;
        @(posedge clock) normal_run_req <= 1'b0;
        vlp_run_req <= 1'b0;
        @(negedge clock);
        chk(mode_q, PMS_VLP_WAIT);
        wait_run();
        chk(mode_q, PMS_VLP_RUN);
        @(posedge clock) deep_sleep_select <= 1'b1;
        stop_level <= PMS_STOP_FULL;
        sleep_now();
        chk({mode_q, lvd_en_q}, {PMS_VLP_STOP, 1'b0});
        chk(lp_periph_en_q, 8'h01);
        @(posedge clock) nrst <= 1'b0;
        @(posedge clock) nrst <= 1'b1;
        @(negedge clock);
        chk({mode_q, core_clk_en_q, lvd_en_q}, {PMS_RUN, 2'h3});
        stop_test();
    end
endmodule // test_pms_sequencer
